// File: rtl/rwa_dev.sv
// Radio register slice: wake status, analog control and channel registers
// Summary of operation
// RQ1: Bit 0 of wake status flags pending wake
// RQ2: Reading wake status returns flag, then clears it
// RQ3: Wake status register ignores all writes
// RQ4: Unlock bit gates writes to protected registers
// RQ5: Identification reads return data only when enabled
// RQ6: Host enables identification read only briefly; host leaves the enable set until a later analog control write
// RQ7: Enable bit drives amplifier control pin
// RQ8: Polarity bit selects active-low amplifier control
// RQ9: Host never changes enable and polarity together
// RQ10: Soft reset bit restores defaults, self-clears
// RQ11: Channel field sets 2400 MHz plus channel
// RQ12: Host programs only channels 2 through 79
// RQ13: Host writes channel before first transmission; host only records chan_written and never blocks tx_active
// RQ14: Host writes zero to reserved bits
// RQ15: Power-down release and ready sets wake flag
// RQ16: Interrupt output follows enabled wake flag
`timescale 1ns/1ns
`default_nettype none
`include "rwa_params.svh"
module rwa_dev #(
	parameter int          WAKE_READY_CYC = (`RWA_WAKE_READY_NS + `RWA_CLK_NS - 1) / `RWA_CLK_NS,
	parameter logic [31:0] FACTORY_ID     = 32'h5a5a_0001 // Arbitrary value
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	rwa_link_if.dev          link,
	input  wire logic        wake_irq_en,
	input  wire logic        tx_active,
	output logic [6:0]       channel,
	output logic [11:0]      synth_freq_mhz,
	output logic             id_read_en,
	output logic [7:0]       prot_reg0,
	output logic [7:0]       prot_reg1
);
	// Parameter checks
	if (WAKE_READY_CYC < 1 || WAKE_READY_CYC > 255) begin : g_chk
		$error("WAKE_READY_CYC out of range");
	end
	if (`RWA_OFF_ID_LO % 4 != 0) begin : g_chk_id
		$error("Identification block not word aligned");
	end

	localparam logic [7:0] READY_LAST = 8'(WAKE_READY_CYC - 1);
	localparam logic [3:0] ID_PAGE    = 4'(`RWA_OFF_ID_LO >> 2);

	// Power-on and soft reset contents
	localparam rwa_pkg::rwa_dev_s RST_STATE = '{
		pd_s1:     1'b1,
		pd_s2:     1'b1,
		wake_st:   rwa_pkg::WK_DOWN,
		ready_cnt: 8'h00,
		wake_pend: 1'(`RWA_RST_WAKE_STAT),
		analog:    `RWA_RST_ANALOG,
		channel:   `RWA_RST_CHANNEL,
		prot0:     `RWA_RST_PROT,
		prot1:     `RWA_RST_PROT,
		ack:       1'b0,
		rdata:     8'h00,
		amp_pin:   1'b0,
		amp_oe:    1'b0,
		irq_n:     1'b1
	};

	rwa_pkg::rwa_dev_s s_q;
	rwa_pkg::rwa_dev_s s_d;
	logic              rd_now;
	logic              wr_now;
	logic [7:0]        rd_val;
	logic              set_wake;
	logic              soft_rst;

	// Register read mux
	always_comb begin
		rd_val = 8'h00;
		case (link.addr)
			`RWA_OFF_WAKE_STAT: begin
				rd_val = {7'h00, s_q.wake_pend}; // see RQ1
			end
			`RWA_OFF_ANALOG: begin
				rd_val = s_q.analog;
			end
			`RWA_OFF_CHANNEL: begin
				rd_val = s_q.channel;
			end
			`RWA_OFF_PROT0: begin
				rd_val = s_q.prot0;
			end
			`RWA_OFF_PROT1: begin
				rd_val = s_q.prot1;
			end
			default: begin
				// Identification bytes, blank while reads are disabled
				if (link.addr[5:2] == ID_PAGE && s_q.analog[`RWA_ANA_ID_RD_EN]) begin
					rd_val = FACTORY_ID[8*link.addr[1:0] +: 8]; // see RQ5
				end
			end
		endcase
	end

	// Next state
	always_comb begin
		s_d = s_q;
		rd_now = link.req && !s_q.ack && !link.we;
		wr_now = link.req && !s_q.ack && link.we;
		soft_rst = wr_now && link.addr == `RWA_OFF_ANALOG && link.wdata[`RWA_ANA_SOFT_RST];
		set_wake = 1'b0;
		// One acknowledge per request
		s_d.ack = link.req && !s_q.ack;
		// Two-stage pin synchroniser
		s_d.pd_s1 = link.power_down_pin;
		s_d.pd_s2 = s_q.pd_s1;
		// Wake sequencing from power-down release
		case (s_q.wake_st)
			rwa_pkg::WK_DOWN: begin
				// Powered down: counter held clear
				s_d.ready_cnt = 8'h00;
				if (!s_q.pd_s2) begin
					s_d.wake_st = rwa_pkg::WK_COUNT;
				end
			end
			rwa_pkg::WK_COUNT: begin
				// Wait until the serial port is ready
				if (s_q.pd_s2) begin
					s_d.wake_st = rwa_pkg::WK_DOWN;
				end else if (s_q.ready_cnt == READY_LAST) begin
					set_wake = 1'b1; // see RQ15
					s_d.wake_st = rwa_pkg::WK_UP;
				end else begin
					s_d.ready_cnt = s_q.ready_cnt + 8'h01;
				end
			end
			rwa_pkg::WK_UP: begin
				// Awake until the next power-down
				if (s_q.pd_s2) begin
					s_d.wake_st = rwa_pkg::WK_DOWN;
				end
			end
			default: s_d.wake_st = rwa_pkg::WK_DOWN;
		endcase
		if (rd_now) begin
			s_d.rdata = rd_val;
		end
		// Read clears the flag, a new wake event wins
		if (rd_now && link.addr == `RWA_OFF_WAKE_STAT) begin
			s_d.wake_pend = 1'b0; // see RQ2
		end
		if (set_wake) begin
			s_d.wake_pend = 1'b1;
		end
		// Wake status has no write path; see RQ3
		if (wr_now) begin
			case (link.addr)
				`RWA_OFF_WAKE_STAT: begin
					// Read-only: write dropped
				end
				`RWA_OFF_ANALOG: begin
					s_d.analog = link.wdata & `RWA_ANA_WR_MASK;
				end
				`RWA_OFF_CHANNEL: begin
					s_d.channel = link.wdata & `RWA_CHAN_MASK; // see RQ11
				end
				`RWA_OFF_PROT0: begin
					if (s_q.analog[`RWA_ANA_WR_UNLOCK]) begin // see RQ4
						s_d.prot0 = link.wdata;
					end
				end
				`RWA_OFF_PROT1: begin
					if (s_q.analog[`RWA_ANA_WR_UNLOCK]) begin // see RQ4
						s_d.prot1 = link.wdata;
					end
				end
				default: begin
					// Unmapped offsets ignore writes
				end
			endcase
		end
		// Soft reset: every register back to default, bit never stored
		if (soft_rst) begin
			s_d.wake_pend = RST_STATE.wake_pend; // see RQ10
			s_d.analog = RST_STATE.analog;
			s_d.channel = RST_STATE.channel;
			s_d.prot0 = RST_STATE.prot0;
			s_d.prot1 = RST_STATE.prot1;
		end
		// Registered pin and interrupt outputs
		s_d.amp_oe = s_d.analog[`RWA_ANA_AMP_OE]; // see RQ7
		s_d.amp_pin = tx_active ^ s_d.analog[`RWA_ANA_AMP_POL]; // see RQ8
		s_d.irq_n = !(s_d.wake_pend && wake_irq_en); // see RQ16
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= RST_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	// Link and pin outputs
	assign link.ack = s_q.ack;
	assign link.rdata = s_q.rdata;
	assign link.irq_n = s_q.irq_n;
	assign link.ext_amp_ctl_pin = s_q.amp_pin;
	assign link.ext_amp_ctl_oe = s_q.amp_oe;
	assign channel = s_q.channel[6:0];
	assign synth_freq_mhz = `RWA_SYNTH_BASE_MHZ + {5'h00, s_q.channel[6:0]}; // see RQ11
	assign id_read_en = s_q.analog[`RWA_ANA_ID_RD_EN];
	assign prot_reg0 = s_q.prot0;
	assign prot_reg1 = s_q.prot1;
endmodule : rwa_dev
`default_nettype wire

// File: rtl/rwa_host.sv
// Host controller: APB command registers driving the radio register link
`timescale 1ns/1ns
`default_nettype none
`include "rwa_params.svh"
module rwa_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	rwa_link_if.host         link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	rwa_pkg::rwa_host_s s_q;
	rwa_pkg::rwa_host_s s_d;
	logic               acc;
	logic               start;
	logic               bad;
	logic [5:0]         c_addr;
	logic [7:0]         c_data;
	logic               c_we;

	always_comb begin
		s_d = s_q;
		acc = psel && penable;
		c_addr = pwdata[13:8];
		c_data = pwdata[7:0];
		c_we = pwdata[`RWA_CMD_WE_BIT];
		start = acc && pwrite && paddr == `RWA_APB_CMD && s_q.st == rwa_pkg::H_IDLE;
		bad = 1'b0;
		s_d.irq_s1 = link.irq_n;
		s_d.irq_s2 = s_q.irq_s1;
		if (c_we && c_addr == `RWA_OFF_ANALOG) begin
			c_data = c_data & `RWA_ANA_WR_MASK | {7'h00, c_data[`RWA_ANA_SOFT_RST]}; // see RQ14
			bad = (c_data[`RWA_ANA_AMP_OE] != s_q.ana_shadow[`RWA_ANA_AMP_OE]) &&
				(c_data[`RWA_ANA_AMP_POL] != s_q.ana_shadow[`RWA_ANA_AMP_POL]); // see RQ9
		end
		if (c_we && c_addr == `RWA_OFF_CHANNEL) begin
			c_data = c_data & `RWA_CHAN_MASK; // see RQ14
			bad = c_data[6:0] < `RWA_CHAN_MIN || c_data[6:0] > `RWA_CHAN_MAX; // see RQ12
		end
		if (!c_we && c_addr[5:2] == 4'(`RWA_OFF_ID_LO >> 2)) begin
			bad = !s_q.ana_shadow[`RWA_ANA_ID_RD_EN]; // see RQ5
		end
		case (s_q.st)
			rwa_pkg::H_IDLE: begin
				if (start) begin
					s_d.refused = bad;
					if (!bad) begin
						s_d.st = rwa_pkg::H_REQ;
						s_d.req = 1'b1;
						s_d.we = c_we;
						s_d.addr = c_addr;
						s_d.wdata = c_data;
					end
				end
			end
			rwa_pkg::H_REQ: begin
				if (link.ack) begin
					s_d.st = rwa_pkg::H_IDLE;
					s_d.req = 1'b0;
					if (!s_q.we) begin
						s_d.rdata = link.rdata;
					end else if (s_q.addr == `RWA_OFF_ANALOG) begin
						s_d.ana_shadow = s_q.wdata[`RWA_ANA_SOFT_RST] ? `RWA_RST_ANALOG
							: s_q.wdata;
						s_d.chan_written = s_q.chan_written && !s_q.wdata[`RWA_ANA_SOFT_RST];
					end else if (s_q.addr == `RWA_OFF_CHANNEL) begin
						s_d.chan_written = 1'b1; // see RQ13
					end
				end
			end
			default: s_d.st = rwa_pkg::H_IDLE;
		endcase
		if (acc && pwrite && paddr == `RWA_APB_PD) begin
			s_d.pd = pwdata[0];
		end
		s_d.pslverr = 1'b0;
		s_d.prdata = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				`RWA_APB_CMD: s_d.prdata = {15'h0, s_q.we, 2'h0, s_q.addr, s_q.wdata};
				`RWA_APB_STAT: s_d.prdata = {20'h00000, s_q.chan_written, s_q.refused,
					!s_q.irq_s2, s_q.st == rwa_pkg::H_REQ, s_q.rdata};
				`RWA_APB_PD: s_d.prdata = {31'h0, s_q.pd};
				default: s_d.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{st: rwa_pkg::H_IDLE, req: 1'b0, we: 1'b0, addr: 6'h00,
				wdata: 8'h00, rdata: 8'h00, ana_shadow: `RWA_RST_ANALOG, refused: 1'b0,
				chan_written: 1'b0, pd: 1'b0, irq_s1: 1'b1, irq_s2: 1'b1,
				prdata: 32'h0000_0000, pslverr: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign link.req = s_q.req;
	assign link.we = s_q.we;
	assign link.addr = s_q.addr;
	assign link.wdata = s_q.wdata;
	assign link.power_down_pin = s_q.pd;
	assign pready = psel && penable;
	assign prdata = s_q.prdata;
	assign pslverr = s_q.pslverr && psel && penable;
endmodule : rwa_host
`default_nettype wire

// File: rtl/rwa_link_if.sv
// Register link between the host controller and the radio register slice
`timescale 1ns/1ns
`default_nettype none
interface rwa_link_if;
	logic       req;
	logic       we;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       ack;
	logic       power_down_pin;
	logic       irq_n;
	logic       ext_amp_ctl_pin;
	logic       ext_amp_ctl_oe;

	modport dev  (input req, we, addr, wdata, power_down_pin,
		output rdata, ack, irq_n, ext_amp_ctl_pin, ext_amp_ctl_oe);
	modport host (output req, we, addr, wdata, power_down_pin,
		input rdata, ack, irq_n, ext_amp_ctl_pin, ext_amp_ctl_oe);
endinterface : rwa_link_if
`default_nettype wire

// File: rtl/rwa_params.svh
// Register offsets, field positions, reset values and timings in ns
`ifndef RWA_PARAMS_SVH
`define RWA_PARAMS_SVH
`define RWA_ADDR_W            6
`define RWA_OFF_WAKE_STAT     6'h1d
`define RWA_OFF_ANALOG        6'h20
`define RWA_OFF_CHANNEL       6'h21
`define RWA_OFF_PROT0         6'h2e
`define RWA_OFF_PROT1         6'h2f
`define RWA_OFF_ID_LO         6'h3c
`define RWA_RST_WAKE_STAT     8'h01
`define RWA_RST_ANALOG        8'h00
`define RWA_RST_CHANNEL       8'h00
`define RWA_RST_PROT          8'h00
`define RWA_ANA_WR_UNLOCK     6
`define RWA_ANA_ID_RD_EN      5
`define RWA_ANA_AMP_OE        2
`define RWA_ANA_AMP_POL       1
`define RWA_ANA_SOFT_RST      0
`define RWA_ANA_WR_MASK       8'h66
`define RWA_CHAN_MASK         8'h7f
`define RWA_CHAN_MIN          7'h02
`define RWA_CHAN_MAX          7'h4f
`define RWA_SYNTH_BASE_MHZ    12'h960
`define RWA_WAKE_READY_NS     200
`define RWA_CLK_NS            10
`define RWA_APB_CMD           12'h000
`define RWA_APB_STAT          12'h004
`define RWA_APB_PD            12'h008
`define RWA_CMD_WE_BIT        16
`define RWA_STAT_BUSY_BIT     8
`define RWA_STAT_IRQ_BIT      9
`define RWA_STAT_REF_BIT      10
`define RWA_STAT_CHW_BIT      11
`endif

// File: rtl/rwa_pkg.sv
// Types shared by both ends of the register link
package rwa_pkg;
	typedef enum logic [1:0] {WK_DOWN, WK_COUNT, WK_UP} rwa_wake_e;
	typedef enum logic {H_IDLE, H_REQ} rwa_host_e;

	typedef struct packed {
		logic       pd_s1;
		logic       pd_s2;
		rwa_wake_e  wake_st;
		logic [7:0] ready_cnt;
		logic       wake_pend;
		logic [7:0] analog;
		logic [7:0] channel;
		logic [7:0] prot0;
		logic [7:0] prot1;
		logic       ack;
		logic [7:0] rdata;
		logic       amp_pin;
		logic       amp_oe;
		logic       irq_n;
	} rwa_dev_s;

	typedef struct packed {
		rwa_host_e  st;
		logic       req;
		logic       we;
		logic [5:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [7:0] ana_shadow;
		logic       refused;
		logic       chan_written;
		logic       pd;
		logic       irq_s1;
		logic       irq_s2;
		logic [31:0] prdata;
		logic       pslverr;
	} rwa_host_s;
endpackage : rwa_pkg

// File: tb/radio_wake_analog_channel_regs_tb.sv
// Self-checking bench for host controller and radio register slice
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module radio_wake_analog_channel_regs_tb;
	localparam logic [31:0] FID = 32'h1234_abcd; // Arbitrary identification value
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tx_active = 1'b0;
	logic [6:0]  channel;
	logic [11:0] synth_freq_mhz;
	logic        id_read_en;
	logic [7:0]  prot_reg0;
	logic [7:0]  prot_reg1;
	logic [31:0] st;
	logic        se;
	logic        rf;
	logic [7:0]  ana;
	logic [6:0]  ch;
	logic [6:0]  cur;
	logic [7:0]  amp [5] = '{8'h04, 8'h06, 8'h00, 8'h04, 8'h00};
	logic [6:0]  chx [6] = '{7'h02, 7'h4f, 7'h00, 7'h01, 7'h50, 7'h7f};
	integer      seed = 32'h2e4b;
	int          err_total = 0;
	int          n_compared = 0;
	rwa_link_if lnk ();
	always #5 pclk = ~pclk;
	rwa_host i_rwa_host (.pclk(pclk), .presetn(presetn), .link(lnk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	rwa_dev #(.WAKE_READY_CYC(2), .FACTORY_ID(FID)) i_rwa_dev (.pclk(pclk),
		.presetn(presetn), .link(lnk), .wake_irq_en(1'b1), .tx_active(tx_active),
		.channel(channel), .synth_freq_mhz(synth_freq_mhz), .id_read_en(id_read_en),
		.prot_reg0(prot_reg0), .prot_reg1(prot_reg1));
	rwa_link_props i_rwa_link_props (.pclk(pclk), .presetn(presetn), .req(lnk.req),
		.we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack),
		.power_down_pin(lnk.power_down_pin), .irq_n(lnk.irq_n),
		.ext_amp_ctl_pin(lnk.ext_amp_ctl_pin), .ext_amp_ctl_oe(lnk.ext_amp_ctl_oe));
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task done(input string s);
		$display("test %s done, mismatches %0d", s, err_total);
	endtask : done
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		st = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			finish_test();
		end
	endtask : apb
	task link(input logic w, input logic [5:0] a, input logic [7:0] d);
		int k;
		apb(1'b1, 12'h000, {15'h0, w, 2'h0, a, d});
		k = 0;
		do begin
			apb(1'b0, 12'h004, 32'h0);
			k++;
		end while (st[8] !== 1'b0 && k < 16);
		if (st[8] !== 1'b0) begin
			err_total++;
			finish_test();
		end
	endtask : link
	task rd(input logic [5:0] a, input logic [7:0] e);
		link(1'b0, a, 8'h00);
		`CHK("link read", e, st[7:0])
	endtask : rd
	initial begin
		int k;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		`CHK("irq after reset", 1'b1, st[9])
		`CHK("chan unwritten", 1'b0, st[11])
		rd(6'h1d, 8'h01);
		rd(6'h1d, 8'h00);
		apb(1'b0, 12'h004, 32'h0);
		`CHK("irq cleared", 1'b0, st[9])
		rd(6'h20, 8'h00);
		rd(6'h21, 8'h00);
		apb(1'b0, 12'h0f0, 32'h0);
		`CHK("unmapped error", 1'b1, se)
		done("reset");
		link(1'b1, 6'h1d, 8'hff);
		rd(6'h1d, 8'h00);
		link(1'b1, 6'h2e, 8'h5a);
		`CHK("locked prot", 8'h00, prot_reg0)
		link(1'b1, 6'h20, 8'h40);
		ch = 7'($random(seed));
		link(1'b1, 6'h2f, {1'b0, ch});
		`CHK("open prot", {1'b0, ch}, prot_reg1)
		done("protect");
		link(1'b1, 6'h20, 8'hb8);
		rd(6'h20, 8'h20);
		`CHK("id enable", 1'b1, id_read_en)
		for (int i = 0; i < 4; i++) rd(6'h3c + 6'(i), FID[8*i +: 8]);
		link(1'b1, 6'h20, 8'h00);
		link(1'b0, 6'h3c, 8'h00);
		`CHK("id refused", 1'b1, st[10])
		done("id");
		ana = 8'h00;
		foreach (amp[i]) begin
			tx_active <= 1'($random(seed));
			link(1'b1, 6'h20, amp[i]);
			rf = ((amp[i] ^ ana) & 8'h06) == 8'h06;
			`CHK("amp refused", rf, st[10])
			if (!rf) ana = amp[i];
			`CHK("amp enable", ana[2], lnk.ext_amp_ctl_oe)
			if (ana[2]) `CHK("amp level", tx_active ^ ana[1], lnk.ext_amp_ctl_pin)
		end
		done("amp");
		cur = 7'h00;
		for (int i = 0; i < 14; i++) begin
			ch = (i < 6) ? chx[i] : 7'($unsigned($random(seed)) % 32'h4e + 32'h2);
			link(1'b1, 6'h21, {1'b0, ch});
			if (ch >= 7'h02 && ch <= 7'h4f) cur = ch;
			`CHK("chan refused", cur != ch, st[10])
			`CHK("channel", cur, channel)
			`CHK("synth", 12'h960 + {5'h0, cur}, synth_freq_mhz)
		end
		`CHK("chan written", 1'b1, st[11])
		done("channel");
		link(1'b1, 6'h20, 8'h44);
		link(1'b1, 6'h20, 8'h01);
		rd(6'h20, 8'h00);
		`CHK("chan flag reset", 1'b0, st[11])
		`CHK("chan reset", 7'h00, channel)
		rd(6'h1d, 8'h01);
		done("soft reset");
		apb(1'b1, 12'h008, 32'h1);
		apb(1'b1, 12'h008, 32'h0);
		k = 0;
		do begin
			apb(1'b0, 12'h004, 32'h0);
			k++;
		end while (st[9] !== 1'b1 && k < 16);
		`CHK("wake irq", 1'b1, st[9])
		rd(6'h1d, 8'h01);
		apb(1'b0, 12'h004, 32'h0);
		`CHK("wake irq cleared", 1'b0, st[9])
		done("wake");
		finish_test();
	end
endmodule : radio_wake_analog_channel_regs_tb
`default_nettype wire

// File: tb/rwa_link_props.sv
// Assertions on the host-to-radio register link
`timescale 1ns/1ns
`default_nettype none
module rwa_link_props (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       req,
	input wire logic       we,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       ack,
	input wire logic       power_down_pin,
	input wire logic       irq_n,
	input wire logic       ext_amp_ctl_pin,
	input wire logic       ext_amp_ctl_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic rd_wake = ack && !we && addr == 6'h1d;
	wire logic wr_ana  = ack && we && addr == 6'h20;
	a_ack_pulse: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_ack_latency: assert property ($rose(req) |=> ack)
		else $error("ack not one cycle after request");
	a_ack_idle: assert property (!req |=> !ack)
		else $error("ack without request");
	a_req_hold: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
		else $error("request changed before ack");
	a_rdata_hold: assert property ($changed(rdata) |-> ack)
		else $error("read data changed outside ack");
	a_wake_reserved: assert property (rd_wake |-> rdata[7:1] == 7'h00)
		else $error("wake status reserved bits set");
	a_oe_cause: assert property ($changed(ext_amp_ctl_oe) |-> wr_ana)
		else $error("amp enable moved without control write");
	a_irq_release: assert property ($rose(irq_n) |-> rd_wake)
		else $error("irq released without status read");
	cover property (rd_wake && rdata[0]);
	cover property (wr_ana && wdata[0]);
	cover property ($fell(power_down_pin));
	cover property ($rose(ext_amp_ctl_pin));
endmodule : rwa_link_props
`default_nettype wire
